// ### src/msc_decode.sv
// Region decode: chip select hits and per-region device width and control style.
`timescale 1ns/10ps
module msc_decode #(
    parameter int unsigned ADDR_W = msc_pkg::ADDR_W
) (
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [ADDR_W-1:0] ram_lo_i,
    input  wire logic [ADDR_W-1:0] ram_hi_i,
    input  wire logic [ADDR_W-1:0] nv_lo_i,
    input  wire logic [ADDR_W-1:0] nv_hi_i,
    input  wire logic              ram_x16_i,
    input  wire logic              ram_five_wire_i,
    input  wire logic              nv_x16_i,
    input  wire logic              nv_five_wire_i,
    output logic                   ram_hit_o,
    output logic                   nv_hit_o,
    output logic                   x16_o,
    output logic                   five_wire_o
);
    function automatic logic in_range(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] lo,
                                      input logic [ADDR_W-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    assign ram_hit_o = in_range(addr_i, ram_lo_i, ram_hi_i);
    // Overlapping windows resolve to RAM so that two devices never drive the bus together.
    assign nv_hit_o = !ram_hit_o && in_range(addr_i, nv_lo_i, nv_hi_i);
    // An unmapped address still runs a cycle, shaped like the RAM region, with no select.
    assign x16_o       = nv_hit_o ? nv_x16_i : ram_x16_i;
    assign five_wire_o = nv_hit_o ? nv_five_wire_i : ram_five_wire_i;
endmodule

// ### src/msc_pkg.sv
// Shared constants and types for the external memory bus strobe controller.
package msc_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned STROBE_NS      = 30;
    localparam int unsigned STROBE_CYC     = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES    = 2;
    localparam int unsigned READ_EXTRA_CYC = SYNC_STAGES + 1;
    localparam int unsigned CNT_W          = 8;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned ADDR_W         = 19;
    localparam logic        PIN_IDLE       = 1'h1;
    localparam logic [15:0] DATA_RST       = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } msc_state_e;
endpackage

// ### src/msc_top.sv
// External memory bus controller: chip selects, read and write strobes, byte enable and data bus drive.
`timescale 1ns/10ps
module msc_top #(
    parameter int unsigned ADDR_W     = msc_pkg::ADDR_W,
    parameter int unsigned STROBE_CYC = msc_pkg::STROBE_CYC
) (
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              req_valid_i,
    input  wire logic              req_wr_i,
    input  wire logic              req_word_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [15:0]       req_wdata_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [15:0]            rsp_rdata_o,
    input  wire logic [ADDR_W-1:0] ram_lo_i,
    input  wire logic [ADDR_W-1:0] ram_hi_i,
    input  wire logic [ADDR_W-1:0] nv_lo_i,
    input  wire logic [ADDR_W-1:0] nv_hi_i,
    input  wire logic              ram_x16_i,
    input  wire logic              ram_five_wire_i,
    input  wire logic              nv_x16_i,
    input  wire logic              nv_five_wire_i,
    output logic [ADDR_W-1:1]      mem_addr_o,
    output logic                   lowest_address_bit_o,
    output logic                   ram_region_select_n_o,
    output logic                   nonvolatile_region_select_n_o,
    output logic                   memory_read_strobe_n_o,
    output logic                   low_byte_write_strobe_n_o,
    output logic                   lower_byte_enable_n_o,
    output logic [15:0]            memory_data_line_o,
    output logic                   memory_data_line_oe_o,
    input  wire logic [15:0]       memory_data_line_i
);
    localparam int unsigned CW = msc_pkg::CNT_W;

    msc_pkg::msc_state_e state_q, state_d;
    logic [CW-1:0]     cnt_q, cnt_d;
    logic              phase_q, phase_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              wr_q, wr_d;
    logic              word_q, word_d;
    logic [15:0]       wdata_q, wdata_d;
    logic              ram_q, ram_d;
    logic              nv_q, nv_d;
    logic              x16_q, x16_d;
    logic              five_q, five_d;
    logic [15:0]       rdata_q, rdata_d;
    logic              rsp_q, rsp_d;
    logic              ready_q, ready_d;
    logic [15:0]       md_s1_q, md_s2_q;

    logic              dec_ram, dec_nv, dec_x16, dec_five;
    logic              acc, two_phase, cur_odd, lo_lane, hi_lane, active, strobe;

    msc_decode #(
        .ADDR_W(ADDR_W)
    ) u_decode (
        .addr_i         (req_addr_i),
        .ram_lo_i       (ram_lo_i),
        .ram_hi_i       (ram_hi_i),
        .nv_lo_i        (nv_lo_i),
        .nv_hi_i        (nv_hi_i),
        .ram_x16_i      (ram_x16_i),
        .ram_five_wire_i(ram_five_wire_i),
        .nv_x16_i       (nv_x16_i),
        .nv_five_wire_i (nv_five_wire_i),
        .ram_hit_o      (dec_ram),
        .nv_hit_o       (dec_nv),
        .x16_o          (dec_x16),
        .five_wire_o    (dec_five)
    );

    assign acc       = req_valid_i && ready_q;
    assign two_phase = !x16_q && word_q;
    assign cur_odd   = !x16_q && (word_q ? !phase_q : addr_q[0]);
    assign lo_lane   = word_q || !addr_q[0];
    assign hi_lane   = word_q || addr_q[0];
    assign active    = (state_q != msc_pkg::ST_IDLE);
    assign strobe    = (state_q == msc_pkg::ST_STROBE);

    // Sequencer: setup, strobe for a fixed count, hold; byte-wide words run the sequence twice.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        phase_d = phase_q;
        addr_d  = addr_q;
        wr_d    = wr_q;
        word_d  = word_q;
        wdata_d = wdata_q;
        ram_d   = ram_q;
        nv_d    = nv_q;
        x16_d   = x16_q;
        five_d  = five_q;
        rdata_d = rdata_q;
        rsp_d   = 1'h0;
        case (state_q)
            msc_pkg::ST_IDLE: begin
                if (acc) begin
                    addr_d  = req_addr_i;
                    wr_d    = req_wr_i;
                    word_d  = req_word_i;
                    wdata_d = req_wdata_i;
                    ram_d   = dec_ram;
                    nv_d    = dec_nv;
                    x16_d   = dec_x16;
                    five_d  = dec_five;
                    phase_d = 1'h0;
                    state_d = msc_pkg::ST_SETUP;
                end
            end
            msc_pkg::ST_SETUP: begin
                // Reads stay in strobe longer so the pin data has crossed the synchroniser.
                cnt_d   = wr_q ? CW'(STROBE_CYC - 1) : CW'(STROBE_CYC + msc_pkg::READ_EXTRA_CYC - 1);
                state_d = msc_pkg::ST_STROBE;
            end
            msc_pkg::ST_STROBE: begin
                if (cnt_q == CW'(0)) begin
                    if (!wr_q) begin
                        if (x16_q) begin
                            rdata_d = md_s2_q;
                        end else if (cur_odd) begin
                            rdata_d[15:8] = md_s2_q[7:0];
                        end else begin
                            rdata_d[7:0] = md_s2_q[7:0];
                        end
                    end
                    state_d = msc_pkg::ST_HOLD;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            msc_pkg::ST_HOLD: begin
                if (two_phase && !phase_q) begin
                    phase_d = 1'h1;
                    state_d = msc_pkg::ST_SETUP;
                end else begin
                    rsp_d   = 1'h1;
                    state_d = msc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = msc_pkg::ST_IDLE;
            end
        endcase
        ready_d = (state_d == msc_pkg::ST_IDLE);
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= msc_pkg::ST_IDLE;
            cnt_q   <= '0;
            phase_q <= 1'h0;
            addr_q  <= '0;
            wr_q    <= 1'h0;
            word_q  <= 1'h0;
            wdata_q <= msc_pkg::DATA_RST;
            ram_q   <= 1'h0;
            nv_q    <= 1'h0;
            x16_q   <= 1'h0;
            five_q  <= 1'h0;
            rdata_q <= msc_pkg::DATA_RST;
            rsp_q   <= 1'h0;
            ready_q <= 1'h0;
            md_s1_q <= msc_pkg::DATA_RST;
            md_s2_q <= msc_pkg::DATA_RST;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            addr_q  <= addr_d;
            wr_q    <= wr_d;
            word_q  <= word_d;
            wdata_q <= wdata_d;
            ram_q   <= ram_d;
            nv_q    <= nv_d;
            x16_q   <= x16_d;
            five_q  <= five_d;
            rdata_q <= rdata_d;
            rsp_q   <= rsp_d;
            ready_q <= ready_d;
            md_s1_q <= memory_data_line_i;
            md_s2_q <= md_s1_q;
        end
    end

    assign req_ready_o = ready_q;
    assign rsp_valid_o = rsp_q;
    assign rsp_rdata_o = rdata_q;

    // Pin stage: every pin is a flop, so pins follow the sequencer state by one cycle.
    logic [ADDR_W-1:1] pa_q, pa_d;
    logic              ma0_q, ma0_d, rcs_q, rcs_d, ncs_q, ncs_d, oe_q, oe_d;
    logic              wel_q, wel_d, lbe_q, lbe_d, mdoe_q, mdoe_d;
    logic [15:0]       md_q, md_d;

    always_comb begin
        pa_d   = addr_q[ADDR_W-1:1];
        rcs_d  = !(active && ram_q);
        ncs_d  = !(active && nv_q);
        oe_d   = !(strobe && !wr_q);
        wel_d  = !(strobe && wr_q && (!x16_q || five_q || lo_lane));
        lbe_d  = !(active && x16_q && five_q && lo_lane);
        mdoe_d = active && wr_q;
        md_d   = x16_q ? wdata_q : {8'h00, (cur_odd ? wdata_q[15:8] : wdata_q[7:0])};
        // The lowest address pin doubles as the high write strobe on word-wide four-wire parts.
        if (!active) begin
            ma0_d = msc_pkg::PIN_IDLE;
        end else if (!x16_q) begin
            ma0_d = cur_odd;
        end else if (five_q) begin
            ma0_d = msc_pkg::PIN_IDLE;
        end else begin
            ma0_d = !(strobe && wr_q && hi_lane);
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pa_q   <= '0;
            ma0_q  <= msc_pkg::PIN_IDLE;
            rcs_q  <= msc_pkg::PIN_IDLE;
            ncs_q  <= msc_pkg::PIN_IDLE;
            oe_q   <= msc_pkg::PIN_IDLE;
            wel_q  <= msc_pkg::PIN_IDLE;
            lbe_q  <= msc_pkg::PIN_IDLE;
            mdoe_q <= 1'h0;
            md_q   <= msc_pkg::DATA_RST;
        end else begin
            pa_q   <= pa_d;
            ma0_q  <= ma0_d;
            rcs_q  <= rcs_d;
            ncs_q  <= ncs_d;
            oe_q   <= oe_d;
            wel_q  <= wel_d;
            lbe_q  <= lbe_d;
            mdoe_q <= mdoe_d;
            md_q   <= md_d;
        end
    end

    assign mem_addr_o                    = pa_q;
    assign lowest_address_bit_o          = ma0_q;
    assign ram_region_select_n_o         = rcs_q;
    assign nonvolatile_region_select_n_o = ncs_q;
    assign memory_read_strobe_n_o        = oe_q;
    assign low_byte_write_strobe_n_o     = wel_q;
    assign lower_byte_enable_n_o         = lbe_q;
    assign memory_data_line_o            = md_q;
    assign memory_data_line_oe_o         = mdoe_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_x8_word_accept;
        acc && !dec_x16 && req_word_i;
    endsequence
    sequence s_odd_then_even;
        ##2 lowest_address_bit_o ##[3:60] !lowest_address_bit_o;
    endsequence

    a_ram_select: assert property (acc && dec_ram |-> ##2 !ram_region_select_n_o)
        else $error("RAM select missing on RAM window cycle");
    a_nv_select: assert property (acc && dec_nv |-> ##2 !nonvolatile_region_select_n_o)
        else $error("NV select missing on NV window cycle");
    a_read_strobe: assert property (acc && !req_wr_i |-> ##3 !memory_read_strobe_n_o)
        else $error("Read strobe missing on read");
    a_read_only: assert property (!memory_read_strobe_n_o |-> !wr_q && !memory_data_line_oe_o)
        else $error("Read strobe active during write");
    a_x8_write: assert property (acc && req_wr_i && !dec_x16 |-> ##3 !low_byte_write_strobe_n_o)
        else $error("Low write strobe missing on byte-wide write");
    a_five_write: assert property (acc && req_wr_i && dec_x16 && dec_five
                                   |-> ##3 !low_byte_write_strobe_n_o && lowest_address_bit_o)
        else $error("Five-wire write strobe wrong");
    a_four_low: assert property (!low_byte_write_strobe_n_o && x16_q && !five_q |-> lo_lane)
        else $error("Four-wire low strobe without low byte");
    a_lbe_low: assert property (acc && dec_x16 && dec_five && (req_word_i || !req_addr_i[0])
                                |-> ##2 !lower_byte_enable_n_o)
        else $error("Lower byte enable missing");
    a_high_strobe: assert property (acc && req_wr_i && dec_x16 && !dec_five && (req_word_i || req_addr_i[0])
                                    |-> ##3 !lowest_address_bit_o)
        else $error("High write strobe missing on four-wire write");
    a_odd_first: assert property (s_x8_word_accept |-> s_odd_then_even)
        else $error("Byte-wide word not split odd byte first");
    a_bus_release: assert property (memory_data_line_oe_o |-> $past(active) && $past(wr_q))
        else $error("Data bus driven outside a write");
endmodule

// ### test/msc_mem_model.sv
// Behavioural external memory that answers reads on the shared data bus.
`timescale 1ns/10ps
module msc_mem_model (
    input  wire logic [msc_pkg::ADDR_W-1:1] mem_addr_i,
    input  wire logic                       ram_sel_n_i,
    input  wire logic                       nv_sel_n_i,
    input  wire logic                       rd_n_i,
    input  wire logic                       lowest_bit_i,
    input  wire logic                       data_oe_i,
    input  wire logic [15:0]                data_i,
    output logic [15:0]                     bus_o
);
    // Released lines settle to their pull levels, mixed up and down per bit.
    localparam logic [15:0] PULL_LEVEL = 16'hCE00;
    logic sel;
    assign sel = !ram_sel_n_i || !nv_sel_n_i;
    // The controller owns the bus while it drives; the memory answers only a selected read.
    always_comb begin
        if (data_oe_i) begin
            bus_o = data_i;
        end else if (sel && !rd_n_i) begin
            // The low byte folds in the lowest address pin so odd and even byte reads differ.
            bus_o = {mem_addr_i[8:1], ~{mem_addr_i[7:1], lowest_bit_i}};
        end else begin
            bus_o = PULL_LEVEL;
        end
    end
endmodule

// ### test/testbench.sv
// Self-checking bench for the memory bus strobe controller.
`timescale 1ns/10ps
module testbench;
    logic                       sys_clk_i = 1'h0;
    logic                       resetn_i  = 1'h0;
    logic                       req_valid, req_wr, req_word, req_ready, rsp_valid;
    logic [msc_pkg::ADDR_W-1:0] req_addr, ram_lo, ram_hi, nv_lo, nv_hi;
    logic [15:0]                req_wdata, rsp_rdata, data_o, bus, rd_last;
    logic                       ram_x16, ram_five, nv_x16, nv_five, oe;
    logic [msc_pkg::ADDR_W-1:1] mem_addr;
    logic                       lab, ram_n, nv_n, rd_n, lo_n, lbe_n, lo_p, lab_p;
    int                         miscompares = 0, check_count = 0;
    int                         lo_falls, hi_falls, ram_cyc, nv_cyc, rd_cyc, lbe_cyc, oe_cyc;
    logic [15:0]                dq[$];
    logic                       lq[$];

    msc_top dut_u (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .req_valid_i(req_valid), .req_wr_i(req_wr),
        .req_word_i(req_word), .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .ram_lo_i(ram_lo), .ram_hi_i(ram_hi), .nv_lo_i(nv_lo),
        .nv_hi_i(nv_hi), .ram_x16_i(ram_x16), .ram_five_wire_i(ram_five), .nv_x16_i(nv_x16),
        .nv_five_wire_i(nv_five), .mem_addr_o(mem_addr), .lowest_address_bit_o(lab),
        .ram_region_select_n_o(ram_n), .nonvolatile_region_select_n_o(nv_n), .memory_read_strobe_n_o(rd_n),
        .low_byte_write_strobe_n_o(lo_n), .lower_byte_enable_n_o(lbe_n), .memory_data_line_o(data_o),
        .memory_data_line_oe_o(oe), .memory_data_line_i(bus));

    msc_mem_model mem_u (.mem_addr_i(mem_addr), .ram_sel_n_i(ram_n), .nv_sel_n_i(nv_n), .rd_n_i(rd_n),
        .lowest_bit_i(lab),
        .data_oe_i(oe), .data_i(data_o), .bus_o(bus));

    always #5 sys_clk_i = ~sys_clk_i;

    // Pins are sampled mid-cycle so registered updates have landed.
    always @(negedge sys_clk_i) begin
        if (lo_p === 1'h1 && lo_n === 1'h0) begin
            lo_falls++;
            dq.push_back(bus);
            lq.push_back(lab);
        end
        if (oe === 1'h1 && lab_p === 1'h1 && lab === 1'h0) hi_falls++;
        if (ram_n === 1'h0) ram_cyc++;
        if (nv_n === 1'h0) nv_cyc++;
        if (rd_n === 1'h0) rd_cyc++;
        if (lbe_n === 1'h0) lbe_cyc++;
        if (oe !== 1'h0) oe_cyc++;
        lo_p = lo_n;
        lab_p = lab;
    end

    task automatic close_out();
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One access: held until taken, then the response pulse is awaited under a bound.
    task automatic op(input logic wr, input logic word, input logic [18:0] a, input logic [15:0] d);
        int n;
        @(negedge sys_clk_i);
        {lo_falls, hi_falls, ram_cyc, nv_cyc, rd_cyc, lbe_cyc, oe_cyc} = '0;
        dq.delete();
        lq.delete();
        @(posedge sys_clk_i);
        req_valid <= 1'h1;
        req_wr    <= wr;
        req_word  <= word;
        req_addr  <= a;
        req_wdata <= d;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (req_ready !== 1'h1 && n < 50);
        @(posedge sys_clk_i);
        req_valid <= 1'h0;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (rsp_valid !== 1'h1 && n < 60);
        chk(rsp_valid, 16'h0001);
        rd_last = rsp_rdata;
        repeat (3) @(negedge sys_clk_i);
        chk(16'(oe_cyc > 0 && !wr), 16'h0000);
    endtask

    task automatic t_ram_word5_write();
        ram_x16  <= 1'h1;
        ram_five <= 1'h1;
        op(1'h1, 1'h1, 19'h00040, 16'hBEEF);
        chk(16'(lo_falls), 16'h0001);
        chk(dq[0], 16'hBEEF);
        chk(16'(lbe_cyc > 0), 16'h0001);
        chk(16'(ram_cyc > 0), 16'h0001);
        chk(16'(nv_cyc), 16'h0000);
        chk(16'(rd_cyc), 16'h0000);
        op(1'h1, 1'h0, 19'h00041, 16'h7E00);
        chk(16'(lo_falls), 16'h0001);
        chk(16'(hi_falls), 16'h0000);
        chk(16'(lbe_cyc), 16'h0000);
        chk(dq[0], 16'h7E00);
    endtask

    task automatic t_nv_word4_read();
        @(posedge sys_clk_i);
        nv_x16  <= 1'h1;
        nv_five <= 1'h0;
        op(1'h0, 1'h1, 19'h10024, 16'h0000);
        chk(rd_last, 16'h12DA);
        chk(16'(nv_cyc > 0), 16'h0001);
        chk(16'(ram_cyc), 16'h0000);
        chk(16'(oe_cyc), 16'h0000);
        chk(16'(lo_falls), 16'h0000);
    endtask

    // Odd lane first, then even lane, on a four-wire word device.
    task automatic t_word4_bytes();
        @(posedge sys_clk_i);
        ram_x16  <= 1'h1;
        ram_five <= 1'h0;
        for (int i = 1; i >= 0; i--) begin
            op(1'h1, 1'h0, 19'h00080 | 19'(i), 16'hA55A);
            chk(16'(lo_falls), 16'(i == 0));
            chk(16'(hi_falls), 16'(i));
            chk(16'(lbe_cyc), 16'h0000);
        end
    endtask

    task automatic t_byte_wide_word();
        @(posedge sys_clk_i);
        ram_x16 <= 1'h0;
        op(1'h1, 1'h1, 19'h00100, 16'hC33C);
        chk(16'(lo_falls), 16'h0002);
        chk({8'h00, dq[0][7:0]}, 16'h00C3);
        chk({8'h00, dq[1][7:0]}, 16'h003C);
        chk({15'h0000, lq[0]}, 16'h0001);
        chk({15'h0000, lq[1]}, 16'h0000);
        chk(16'(ram_cyc > 0), 16'h0001);
        op(1'h1, 1'h0, 19'h00101, 16'h5AA5);
        chk(16'(lo_falls), 16'h0001);
        chk(dq[0], 16'h005A);
        chk({15'h0000, lq[0]}, 16'h0001);
    endtask

    // Byte-wide word read: the odd byte returns in the high lane, the even byte in the low lane.
    task automatic t_nv_byte_word_read();
        @(posedge sys_clk_i);
        nv_x16 <= 1'h0;
        op(1'h0, 1'h1, 19'h10024, 16'h0000);
        chk(rd_last, 16'hDADB);
        chk(16'(rd_cyc), 16'(2 * (msc_pkg::STROBE_CYC + msc_pkg::READ_EXTRA_CYC)));
        chk(16'(nv_cyc > 0), 16'h0001);
        chk(16'(lo_falls), 16'h0000);
    endtask

    initial begin
        {req_valid, req_wr, req_word, ram_x16, ram_five, nv_x16, nv_five} = '0;
        req_addr  = 19'h00000;
        req_wdata = 16'h0000;
        ram_lo    = 19'h00000;
        ram_hi    = 19'h0FFFF;
        nv_lo     = 19'h10000;
        nv_hi     = 19'h1FFFF;
        lo_p      = 1'h1;
        lab_p     = 1'h1;
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'h1;
        @(posedge sys_clk_i);
        t_ram_word5_write();
        t_nv_word4_read();
        t_word4_bytes();
        t_byte_wide_word();
        t_nv_byte_word_read();
        close_out();
    end

    // The sequence needs little more than a hundred cycles; this limit is far beyond that.
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
endmodule
